// ===== core/protection_status_cfg.svh
// Command codes, bit positions and input indices for the protection status recorder.
// Assumes inclusion by bare name from files under core/ and verif/.
`ifndef PROTECTION_STATUS_CFG_SVH
`define PROTECTION_STATUS_CFG_SVH

`define CMD_CLEAR_FAULTS       8'h03
`define CMD_SHUTDOWN_CAUSE     8'h7C
`define CMD_TEMP_STATUS        8'h7D

// Shutdown cause record bit positions
`define SC_POWER_STAGE_OC      11
`define SC_SUSTAINED_OC        9
`define SC_REPEATED_SPIKE      8
`define SC_INPUT_OV            7
`define SC_INPUT_UVLO          6
`define SC_TEMP_PIN_OT         5
`define SC_DIE_OT              4
`define SC_OUT_OV_ABS          3
`define SC_OUT_OV_TARGET       2
`define SC_OUT_UV_TARGET       1
`define SC_OUT_UV_FLOOR        0
`define SC_USED_MASK           16'h0BFF

// Temperature status bit positions
`define TS_TEMP_PIN_OT         7
`define TS_DIE_OT              6
`define TS_POWER_STAGE_OC      5
`define TS_USED_MASK           8'hE0

// Indices into the asynchronous fault input vector
`define FI_TEMP_PIN_ABOVE_1V8  0
`define FI_SUSTAINED_OC        1
`define FI_REPEATED_SPIKE      2
`define FI_INPUT_OV            3
`define FI_INPUT_UVLO          4
`define FI_TEMP_PIN_OT         5
`define FI_DIE_OT              6
`define FI_OUT_OV_ABS          7
`define FI_OUT_OV_TARGET       8
`define FI_OUT_UV_TARGET       9
`define FI_OUT_UV_FLOOR        10
`define FI_COUNT               11

`define CAUSE_RESET            16'h0000
`define TEMP_RESET             8'h00

`endif

// ===== core/protection_status_pkg.sv
// Types shared by the protection status recorder.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package protection_status_pkg;
    typedef logic [15:0] cause_rec_t;
    typedef logic [7:0]  temp_stat_t;
    typedef logic [7:0]  cmd_code_t;
endpackage
`default_nettype wire

// ===== core/protection_status_recorder.sv
// Shutdown cause record and temperature-pin status register with command-code read port.
// Assumes fault inputs are asynchronous comparator/protection levels; the rest is on mclk.
//
// Notes on behaviour
// - Temperature pin above 1.8V sets and holds cause bit 11.
// - Sustained overcurrent protection sets and holds cause bit 9.
// - Repeated current spike protection sets and holds cause bit 8.
// - Input over-voltage protection sets and holds cause bit 7.
// - Lockout while delivering power, or with startup record enable, sets cause bit 6.
// - Temperature-pin over-temperature protection sets and holds cause bit 5.
// - Die over-temperature protection sets and holds cause bit 4.
// - Absolute output over-voltage protection sets and holds cause bit 3.
// - Output over-voltage against target sets and holds cause bit 2.
// - Output under-voltage against target sets and holds cause bit 1.
// - Output under-voltage below floor sets and holds cause bit 0.
// - Cause record can be saved to, and restored from, the nonvolatile store.
// - Reserved bits read zero: cause 15:12 and 10, temperature 4:0.
// - Temperature status clears on clear-faults, reset, or restart when enabled.
// - Sampled temperature-pin over-temperature sets and holds temperature bit 7.
// - Die over-temperature sets and holds temperature bit 6.
// - Pin above 1.8V alone, the power-stage overcurrent flag, sets temperature bit 5.
// - A one in any flag means that fault occurred.
`default_nettype none
`include "protection_status_cfg.svh"

module protection_status_recorder
    import protection_status_pkg::*;
(
    input  wire logic                 mclk,               // System clock, 250 MHz
    input  wire logic                 rst,                // Synchronous reset, power cycle
    input  wire logic [`FI_COUNT-1:0] fault_async,        // Asynchronous fault levels
    input  wire logic                 delivering_power,   // Converter is delivering power
    input  wire logic                 startup_lockout_record_enable, // Record lockout at startup
    input  wire logic                 restart_clear_enable, // Restart clears temperature status
    input  wire logic                 restart_pulse,      // Enable or operation restart event
    input  wire logic                 cmd_valid,          // Command strobe from host side
    input  wire logic                 cmd_read,           // 1 read, 0 write or send byte
    input  wire cmd_code_t            cmd_code,           // Command code
    output var  cause_rec_t           rd_data_q,          // Read data, low aligned
    output var  logic                 rd_valid_q,         // Read answer pulse
    output var  logic                 rd_hit_q,           // Read addressed a register here
    input  wire logic                 nv_store_req,       // Save cause record request
    output var  cause_rec_t           nv_store_data_q,    // Record snapshot for the store
    output var  logic                 nv_store_valid_q,   // Snapshot valid pulse
    input  wire logic                 nv_restore_valid,   // Restore record from store
    input  wire cause_rec_t           nv_restore_data,    // Restored record
    output var  cause_rec_t           shutdown_cause_record_q, // Live cause record
    output var  temp_stat_t           temperature_pin_status_q // Live temperature status
);

    logic [`FI_COUNT-1:0] sync1_q;
    logic [`FI_COUNT-1:0] fault_q;

    // Only the second stage is read
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_q <= '0;
            fault_q <= '0;
        end else begin
            sync1_q <= fault_async;
            fault_q <= sync1_q;
        end
    end

    cause_rec_t cause_set;
    temp_stat_t temp_set;
    logic       temp_clear;

    always_comb begin
        cause_set = `CAUSE_RESET;
        cause_set[`SC_POWER_STAGE_OC] = fault_q[`FI_TEMP_PIN_ABOVE_1V8];
        cause_set[`SC_SUSTAINED_OC]   = fault_q[`FI_SUSTAINED_OC];
        cause_set[`SC_REPEATED_SPIKE] = fault_q[`FI_REPEATED_SPIKE];
        cause_set[`SC_INPUT_OV]       = fault_q[`FI_INPUT_OV];
        cause_set[`SC_INPUT_UVLO]     = fault_q[`FI_INPUT_UVLO]
                                        & (delivering_power | startup_lockout_record_enable);
        cause_set[`SC_TEMP_PIN_OT]    = fault_q[`FI_TEMP_PIN_OT];
        cause_set[`SC_DIE_OT]         = fault_q[`FI_DIE_OT];
        cause_set[`SC_OUT_OV_ABS]     = fault_q[`FI_OUT_OV_ABS];
        cause_set[`SC_OUT_OV_TARGET]  = fault_q[`FI_OUT_OV_TARGET];
        cause_set[`SC_OUT_UV_TARGET]  = fault_q[`FI_OUT_UV_TARGET];
        cause_set[`SC_OUT_UV_FLOOR]   = fault_q[`FI_OUT_UV_FLOOR];
        temp_set = `TEMP_RESET;
        temp_set[`TS_TEMP_PIN_OT]    = fault_q[`FI_TEMP_PIN_OT];
        temp_set[`TS_DIE_OT]         = fault_q[`FI_DIE_OT];
        temp_set[`TS_POWER_STAGE_OC] = fault_q[`FI_TEMP_PIN_ABOVE_1V8];
    end

    // Clear-faults is a write-type command; restart clears only when enabled
    assign temp_clear = (cmd_valid & ~cmd_read & (cmd_code == `CMD_CLEAR_FAULTS))
                        | (restart_pulse & restart_clear_enable);

    // Cause flags: no clear command reaches them, only reset or a restore
    logic pin_oc_cause_q;
    logic sus_oc_cause_q;
    logic spike_cause_q;
    logic in_ov_cause_q;
    logic in_uvlo_cause_q;
    logic pin_ot_cause_q;
    logic die_ot_cause_q;
    logic ov_abs_cause_q;
    logic ov_tgt_cause_q;
    logic uv_tgt_cause_q;
    logic uv_floor_cause_q;
    logic pin_ot_stat_q;
    logic die_ot_stat_q;
    logic pin_oc_stat_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_oc_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            pin_oc_cause_q <= nv_restore_data[`SC_POWER_STAGE_OC] | cause_set[`SC_POWER_STAGE_OC];
        end else begin
            pin_oc_cause_q <= pin_oc_cause_q | cause_set[`SC_POWER_STAGE_OC];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sus_oc_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            sus_oc_cause_q <= nv_restore_data[`SC_SUSTAINED_OC] | cause_set[`SC_SUSTAINED_OC];
        end else begin
            sus_oc_cause_q <= sus_oc_cause_q | cause_set[`SC_SUSTAINED_OC];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            spike_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            spike_cause_q <= nv_restore_data[`SC_REPEATED_SPIKE] | cause_set[`SC_REPEATED_SPIKE];
        end else begin
            spike_cause_q <= spike_cause_q | cause_set[`SC_REPEATED_SPIKE];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            in_ov_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            in_ov_cause_q <= nv_restore_data[`SC_INPUT_OV] | cause_set[`SC_INPUT_OV];
        end else begin
            in_ov_cause_q <= in_ov_cause_q | cause_set[`SC_INPUT_OV];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            in_uvlo_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            in_uvlo_cause_q <= nv_restore_data[`SC_INPUT_UVLO] | cause_set[`SC_INPUT_UVLO];
        end else begin
            in_uvlo_cause_q <= in_uvlo_cause_q | cause_set[`SC_INPUT_UVLO];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_ot_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            pin_ot_cause_q <= nv_restore_data[`SC_TEMP_PIN_OT] | cause_set[`SC_TEMP_PIN_OT];
        end else begin
            pin_ot_cause_q <= pin_ot_cause_q | cause_set[`SC_TEMP_PIN_OT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            die_ot_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            die_ot_cause_q <= nv_restore_data[`SC_DIE_OT] | cause_set[`SC_DIE_OT];
        end else begin
            die_ot_cause_q <= die_ot_cause_q | cause_set[`SC_DIE_OT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ov_abs_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            ov_abs_cause_q <= nv_restore_data[`SC_OUT_OV_ABS] | cause_set[`SC_OUT_OV_ABS];
        end else begin
            ov_abs_cause_q <= ov_abs_cause_q | cause_set[`SC_OUT_OV_ABS];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ov_tgt_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            ov_tgt_cause_q <= nv_restore_data[`SC_OUT_OV_TARGET] | cause_set[`SC_OUT_OV_TARGET];
        end else begin
            ov_tgt_cause_q <= ov_tgt_cause_q | cause_set[`SC_OUT_OV_TARGET];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            uv_tgt_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            uv_tgt_cause_q <= nv_restore_data[`SC_OUT_UV_TARGET] | cause_set[`SC_OUT_UV_TARGET];
        end else begin
            uv_tgt_cause_q <= uv_tgt_cause_q | cause_set[`SC_OUT_UV_TARGET];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            uv_floor_cause_q <= 1'b0;
        end else if (nv_restore_valid) begin
            uv_floor_cause_q <= nv_restore_data[`SC_OUT_UV_FLOOR] | cause_set[`SC_OUT_UV_FLOOR];
        end else begin
            uv_floor_cause_q <= uv_floor_cause_q | cause_set[`SC_OUT_UV_FLOOR];
        end
    end

    // Set wins over clear so a fault present at the clear is kept
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_ot_stat_q <= 1'b0;
        end else if (temp_clear) begin
            pin_ot_stat_q <= temp_set[`TS_TEMP_PIN_OT];
        end else begin
            pin_ot_stat_q <= pin_ot_stat_q | temp_set[`TS_TEMP_PIN_OT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            die_ot_stat_q <= 1'b0;
        end else if (temp_clear) begin
            die_ot_stat_q <= temp_set[`TS_DIE_OT];
        end else begin
            die_ot_stat_q <= die_ot_stat_q | temp_set[`TS_DIE_OT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_oc_stat_q <= 1'b0;
        end else if (temp_clear) begin
            pin_oc_stat_q <= temp_set[`TS_POWER_STAGE_OC];
        end else begin
            pin_oc_stat_q <= pin_oc_stat_q | temp_set[`TS_POWER_STAGE_OC];
        end
    end

    // Reserved positions are constants, so no restore can set them
    always_comb begin
        shutdown_cause_record_q                     = `CAUSE_RESET;
        shutdown_cause_record_q[`SC_POWER_STAGE_OC] = pin_oc_cause_q;
        shutdown_cause_record_q[`SC_SUSTAINED_OC]   = sus_oc_cause_q;
        shutdown_cause_record_q[`SC_REPEATED_SPIKE] = spike_cause_q;
        shutdown_cause_record_q[`SC_INPUT_OV]       = in_ov_cause_q;
        shutdown_cause_record_q[`SC_INPUT_UVLO]     = in_uvlo_cause_q;
        shutdown_cause_record_q[`SC_TEMP_PIN_OT]    = pin_ot_cause_q;
        shutdown_cause_record_q[`SC_DIE_OT]         = die_ot_cause_q;
        shutdown_cause_record_q[`SC_OUT_OV_ABS]     = ov_abs_cause_q;
        shutdown_cause_record_q[`SC_OUT_OV_TARGET]  = ov_tgt_cause_q;
        shutdown_cause_record_q[`SC_OUT_UV_TARGET]  = uv_tgt_cause_q;
        shutdown_cause_record_q[`SC_OUT_UV_FLOOR]   = uv_floor_cause_q;
        temperature_pin_status_q                     = `TEMP_RESET;
        temperature_pin_status_q[`TS_TEMP_PIN_OT]    = pin_ot_stat_q;
        temperature_pin_status_q[`TS_DIE_OT]         = die_ot_stat_q;
        temperature_pin_status_q[`TS_POWER_STAGE_OC] = pin_oc_stat_q;
    end

    // Writes to either register fall through here untouched
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data_q  <= `CAUSE_RESET;
            rd_valid_q <= 1'b0;
            rd_hit_q   <= 1'b0;
        end else begin
            rd_valid_q <= cmd_valid & cmd_read;
            rd_hit_q   <= 1'b0;
            rd_data_q  <= `CAUSE_RESET;
            if (cmd_valid & cmd_read) begin
                case (cmd_code)
                    `CMD_SHUTDOWN_CAUSE: begin
                        rd_data_q <= shutdown_cause_record_q & `SC_USED_MASK;
                        rd_hit_q  <= 1'b1;
                    end
                    `CMD_TEMP_STATUS: begin
                        rd_data_q <= {8'h00, temperature_pin_status_q & `TS_USED_MASK};
                        rd_hit_q  <= 1'b1;
                    end
                    default: begin
                        rd_hit_q  <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            nv_store_data_q  <= `CAUSE_RESET;
            nv_store_valid_q <= 1'b0;
        end else begin
            nv_store_valid_q <= nv_store_req;
            if (nv_store_req) begin
                nv_store_data_q <= shutdown_cause_record_q;
            end
        end
    end

endmodule
`default_nettype wire

// ===== verif/protection_status_recorder_monitor.sv
// Checker for read answers, reserved bits, flag holding, clearing and the store snapshot.
// Assumes it is bound onto the recorder; a fault held for three edges has reached the flags.
`default_nettype none
`include "protection_status_cfg.svh"
module protection_status_recorder_monitor
    import protection_status_pkg::*;
(
    input wire logic mclk, rst, cmd_valid, cmd_read, rd_valid_q, rd_hit_q, restart_pulse, restart_clear_enable,
    input wire logic nv_store_req, nv_store_valid_q, nv_restore_valid,
    input wire logic [`FI_COUNT-1:0] fault_async,
    input wire cmd_code_t cmd_code,
    input wire cause_rec_t rd_data_q, nv_store_data_q, shutdown_cause_record_q,
    input wire temp_stat_t temperature_pin_status_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic rq = cmd_valid && cmd_read;
    wire logic hit = cmd_code == 8'h7C || cmd_code == 8'h7D;
    wire logic clr = (cmd_valid && !cmd_read && cmd_code == 8'h03) || (restart_pulse && restart_clear_enable);
    a_read_answer: assert property (rq |=> rd_valid_q && rd_hit_q == $past(hit))
        else $error("read answer missing or hit flag wrong");
    a_no_stray_answer: assert property (!rq |=> !rd_valid_q && rd_data_q == 16'h0000)
        else $error("answer or data without a read");
    a_reserved_zero: assert property ((shutdown_cause_record_q & 16'hF400) == 0 && (temperature_pin_status_q & 8'h1F) == 0)
        else $error("reserved status bit set");
    a_cause_hold: assert property (!nv_restore_valid |=> (shutdown_cause_record_q & $past(shutdown_cause_record_q)) == $past(shutdown_cause_record_q))
        else $error("cause flag dropped");
    a_temp_hold: assert property (!clr |=> (temperature_pin_status_q & $past(temperature_pin_status_q)) == $past(temperature_pin_status_q))
        else $error("temperature flag dropped without clear");
    a_clear_empties: assert property ((fault_async == 0) [*3] ##0 clr |=> temperature_pin_status_q == 8'h00)
        else $error("temperature status not cleared");
    a_pin_oc_flags: assert property (fault_async[`FI_TEMP_PIN_ABOVE_1V8] [*3] |=> shutdown_cause_record_q[11] && temperature_pin_status_q[5])
        else $error("pin overcurrent flags not set");
    a_die_ot_flags: assert property (fault_async[`FI_DIE_OT] [*3] |=> shutdown_cause_record_q[4] && temperature_pin_status_q[6])
        else $error("die temperature flags not set");
    a_store_snapshot: assert property (nv_store_req |=> nv_store_valid_q && nv_store_data_q == $past(shutdown_cause_record_q))
        else $error("store snapshot wrong");
endmodule
bind protection_status_recorder protection_status_recorder_monitor i_mon (.mclk, .rst, .cmd_valid, .cmd_read, .rd_valid_q,
    .rd_hit_q, .restart_pulse, .restart_clear_enable, .nv_store_req, .nv_store_valid_q, .nv_restore_valid,
    .fault_async, .cmd_code, .rd_data_q, .nv_store_data_q, .shutdown_cause_record_q, .temperature_pin_status_q);
`default_nettype wire

// ===== verif/status_host_model.sv
// Host-side command master: one command per call, answer taken one edge later.
// Assumes the caller is in the mclk domain.
`default_nettype none
module status_host_model
    import protection_status_pkg::*;
(
    input  wire logic       mclk,       // System clock
    output var  logic       cmd_valid,  // Command strobe
    output var  logic       cmd_read,   // Read when high
    output var  cmd_code_t  cmd_code,   // Command code
    input  wire cause_rec_t rd_data_q,  // Answer data
    input  wire logic       rd_valid_q, // Answer pulse
    input  wire logic       rd_hit_q    // Register hit
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {cmd_valid, cmd_read, cmd_code} = {1'b0, 1'b1, 8'hA5};
    task automatic xfer(input logic rd, input cmd_code_t c, output cause_rec_t d, output logic v, output logic h);
        @(posedge mclk);
        #1 {cmd_valid, cmd_read, cmd_code} = {1'b1, rd, c};
        @(posedge mclk);
        #1 {d, v, h} = {rd_data_q, rd_valid_q, rd_hit_q};
        // Idle bus shows inverted lines so a stale code cannot pass
        {cmd_valid, cmd_read, cmd_code} = {1'b0, ~rd, ~c};
    endtask
endmodule
`default_nettype wire

// ===== verif/protection_status_recorder_tb.sv
// Bench: fault pulses timed off a 48 ns link clock, host reads, clears, restarts and store paths.
// Assumes the host model and the bound checker are compiled with the design.
`default_nettype none
`include "protection_status_cfg.svh"
module protection_status_recorder_tb
    import protection_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 mclk, lclk, rst, dp, sle, rce, rp, nsr, nrv, cv, cr, v, h, rv, rh, sv;
    logic [`FI_COUNT-1:0] fa;
    cmd_code_t            cc;
    cause_rec_t           rd, sd, nrd, rec, d;
    temp_stat_t           ts;
    logic [31:0]          seed = 32'hC318;
    int                   mismatches, samples_checked, cyc, exp_c, exp_t, i, b;
    protection_status_recorder i_protection_status_recorder (.mclk, .rst, .fault_async(fa), .delivering_power(dp),
        .startup_lockout_record_enable(sle), .restart_clear_enable(rce), .restart_pulse(rp), .cmd_valid(cv),
        .cmd_read(cr), .cmd_code(cc), .rd_data_q(rd), .rd_valid_q(rv), .rd_hit_q(rh), .nv_store_req(nsr),
        .nv_store_data_q(sd), .nv_store_valid_q(sv), .nv_restore_valid(nrv), .nv_restore_data(nrd),
        .shutdown_cause_record_q(rec), .temperature_pin_status_q(ts));
    status_host_model i_status_host_model (.mclk, .cmd_valid(cv), .cmd_read(cr), .cmd_code(cc), .rd_data_q(rd),
        .rd_valid_q(rv), .rd_hit_q(rh));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        lclk = 1'b0;
        forever #24 lclk = ~lclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_both();
        i_status_host_model.xfer(1'b1, 8'h7C, d, v, h);
        chk({v, h, d}, {2'b11, exp_c[15:0]});
        i_status_host_model.xfer(1'b1, 8'h7D, d, v, h);
        chk({v, h, d}, {2'b11, 8'h00, exp_t[7:0]});
        chk({2'b00, rec}, {2'b00, exp_c[15:0]});
        chk({10'h000, ts}, {10'h000, exp_t[7:0]});
    endtask
    // Faults rise and fall 1 ns after the first mclk edge following a link edge
    task automatic pulse(input int idx);
        @(posedge lclk);
        @(posedge mclk);
        #1 fa[idx] = 1'b1;
        @(posedge lclk);
        @(posedge mclk);
        #1 fa[idx] = 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        {fa, dp, sle, rce, rp, nsr, nrv, nrd} = '0;
        rst = 1'b1;
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        rd_both();
        for (i = 0; i < `FI_COUNT; i++) begin
            b = xs();
            {sle, dp} = b[1:0];
            pulse(i);
            if (i != 4 || b[1:0] != 0) exp_c |= 1 << (i == 0 ? 11 : 10 - i);
            exp_t |= i == 0 ? 32 : i == 5 ? 128 : i == 6 ? 64 : 0;
            i_status_host_model.xfer(1'b0, b[0] ? 8'h7C : 8'h7D, d, v, h);
            chk({v, h, d}, 18'h00000);
            rd_both();
        end
        for (b = 0; b < 2; b++) begin
            rce = b[0];
            @(posedge mclk);
            #1 rp = 1'b1;
            @(posedge mclk);
            #1 rp = 1'b0;
            exp_t = b ? 0 : exp_t;
            rd_both();
            pulse(`FI_TEMP_PIN_OT);
            exp_t |= 128;
        end
        i_status_host_model.xfer(1'b0, 8'h03, d, v, h);
        exp_t = 0;
        chk({v, h, d}, 18'h0);
        rd_both();
        i_status_host_model.xfer(1'b1, 8'h7E, d, v, h);
        chk({v, h, d}, {2'b10, 16'h0000});
        nsr = 1'b1;
        @(posedge mclk);
        #1 nsr = 1'b0;
        chk({sv, 1'b0, sd}, {2'b10, exp_c[15:0]});
        b = xs();
        nrd = b[15:0];
        nrv = 1'b1;
        @(posedge mclk);
        #1 nrv = 1'b0;
        exp_c = b & 16'h0BFF;
        rd_both();
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        {exp_c, exp_t} = '0;
        rd_both();
        {sle, dp} = 2'b00;
        pulse(`FI_INPUT_UVLO);
        rd_both();
        {sle, dp} = 2'b10;
        pulse(`FI_INPUT_UVLO);
        exp_c = 64;
        rd_both();
        report_and_stop();
    end
endmodule
`default_nettype wire
